/* sys_integrity_pkg.sv */
// constants, types and decode for the system integrity register bank
package sys_integrity_pkg;
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned HALVE_DELAY_NS = 250;
  localparam int unsigned HALVE_CYC      = (HALVE_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  OFF_STATUS     = 8'h00;
  localparam logic [7:0]  OFF_CLKTEST    = 8'h04;
  localparam logic [7:0]  OFF_IRQ_STAT   = 8'h08;
  localparam logic [7:0]  OFF_IRQ_MASK   = 8'h0c;
  localparam int unsigned BIT_WDG        = 4;
  localparam int unsigned BIT_HALVE      = 7;
  localparam int unsigned IRQ_WARN       = 0;
  localparam int unsigned IRQ_UNLOCK     = 1;
  localparam int unsigned IRQ_W          = 2;
  localparam logic [1:0]  TRIM_RESET     = 2'h3;
  localparam logic [1:0]  IRQ_MASK_RESET = 2'h0;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef struct packed {
    logic       fast_multiplier_locked;
    logic [1:0] osc_trim_low;
    logic       watchdog_reset_flag;
    logic       multiplier_locked;
    logic       supply_drop_reset_flag;
    logic       supply_warning_flag;
    logic       supply_warning_irq_en;
  } system_integrity_status_t;

  typedef struct packed {
    logic fast_lock;
    logic main_lock;
    logic supply_low;
  } analog_in_t;

  typedef enum logic [2:0] {
    SEL_STATUS   = 3'h0,
    SEL_CLKTEST  = 3'h1,
    SEL_IRQ_STAT = 3'h3,
    SEL_IRQ_MASK = 3'h2,
    SEL_NONE     = 3'h6
  } reg_sel_t;

  function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a == OFF_STATUS) s = SEL_STATUS;
    else if (a == OFF_CLKTEST) s = SEL_CLKTEST;
    else if (a == OFF_IRQ_STAT) s = SEL_IRQ_STAT;
    else if (a == OFF_IRQ_MASK) s = SEL_IRQ_MASK;
    return s;
  endfunction : decode_addr
endpackage : sys_integrity_pkg

/* level_sync.sv */
// two-stage synchroniser for asynchronous levels
`timescale 1ns/1ps
module level_sync
  import sys_integrity_pkg::*;
#(
  parameter int unsigned W = 1
)(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  generate
    if (W < 1) begin : g_bad
      $error("level_sync width must be at least one");
    end
  endgenerate

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : level_sync

/* settle_delay.sv */
// passes a level on only after it has differed for n cycles
`timescale 1ns/1ps
module settle_delay
  import sys_integrity_pkg::*;
#(
  parameter int unsigned N = HALVE_CYC
)(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  localparam int unsigned CW = (N < 2) ? 1 : $clog2(N);
  logic [CW-1:0] cnt_q;

  generate
    if (N < 1) begin : g_bad
      $error("settle_delay count must be at least one");
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      q     <= 1'b0;
    end
    else if (d == q)
      cnt_q <= '0;
    else if (cnt_q == CW'(N - 1))
    begin
      cnt_q <= '0;
      q     <= d;
    end
    else
      cnt_q <= cnt_q + CW'(1);
  end
endmodule : settle_delay

/* system_integrity_status_regs.sv */
// system integrity status and clock test registers behind axi4-lite
`timescale 1ns/1ps
module system_integrity_status_regs
  import sys_integrity_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              por_n,
  input  wire logic              cause_watchdog,
  input  wire logic              cause_supply_drop,
  input  wire logic              fast_lock_async,
  input  wire logic              main_lock_async,
  input  wire logic              supply_low_async,
  input  wire logic              irq_service_ack,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   irq,
  output logic [1:0]             osc_trim_low,
  output logic                   multiplier_halve
);
  analog_in_t               ana_s;
  logic                     warn_prev_q;
  logic                     lock_prev_q;
  logic                     wdg_q;
  logic                     drop_q;
  logic                     irq_en_q;
  logic                     halve_q;
  logic [IRQ_W-1:0]         irq_stat_q;
  logic [IRQ_W-1:0]         irq_mask_q;
  logic                     aw_ok_q;
  logic                     w_ok_q;
  logic [ADDR_W-1:0]        waddr_q;
  logic [7:0]               wbyte_q;
  logic                     wlane_q;
  logic                     wr_en;
  logic                     rd_clr;
  logic                     warn_evt;
  logic                     unlock_evt;
  reg_sel_t                 wsel;
  reg_sel_t                 rsel;
  system_integrity_status_t status_v;

  level_sync #(
    .W (3)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({fast_lock_async, main_lock_async, supply_low_async}),
    .sync_out (ana_s)
  );

  settle_delay #(
    .N (HALVE_CYC)
  ) u_halve (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (halve_q),
    .q     (multiplier_halve)
  );

  assign wsel   = decode_addr(waddr_q);
  assign rsel   = decode_addr(araddr);
  assign wr_en  = aw_ok_q && w_ok_q && !bvalid;
  assign rd_clr = arvalid && arready && (rsel == SEL_STATUS);

  // live view of the status register
  always_comb
  begin
    status_v.fast_multiplier_locked = ana_s.fast_lock;
    status_v.osc_trim_low           = osc_trim_low;
    status_v.watchdog_reset_flag    = wdg_q;
    status_v.multiplier_locked      = ana_s.main_lock;
    status_v.supply_drop_reset_flag = drop_q;
    status_v.supply_warning_flag    = ana_s.supply_low;
    status_v.supply_warning_irq_en  = irq_en_q;
  end

  // write channel
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      awready <= 1'b1;
      wready  <= 1'b1;
      aw_ok_q <= 1'b0;
      w_ok_q  <= 1'b0;
      waddr_q <= '0;
      wbyte_q <= '0;
      wlane_q <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        waddr_q <= awaddr;
        aw_ok_q <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wbyte_q <= wdata[7:0];
        wlane_q <= wstrb[0];
        w_ok_q  <= 1'b1;
        wready  <= 1'b0;
      end
      if (wr_en)
      begin
        aw_ok_q <= 1'b0;
        w_ok_q  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // read channel
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (rsel)
        SEL_STATUS:   rdata <= {24'h000000, status_v};
        SEL_CLKTEST:  rdata <= {24'h000000, halve_q, 7'h00};
        SEL_IRQ_STAT: rdata <= {30'h00000000, irq_stat_q};
        SEL_IRQ_MASK: rdata <= {30'h00000000, irq_mask_q};
        default:      rdata <= '0;
      endcase
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // software controlled fields
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      osc_trim_low <= TRIM_RESET;
      irq_en_q     <= 1'b0;
      halve_q      <= 1'b0;
      irq_mask_q   <= IRQ_MASK_RESET;
    end
    else if (wr_en && wlane_q)
    begin
      if (wsel == SEL_STATUS)
      begin
        osc_trim_low <= wbyte_q[6:5];
        irq_en_q     <= wbyte_q[0];
      end
      if (wsel == SEL_CLKTEST)
        halve_q <= wbyte_q[BIT_HALVE];
      if (wsel == SEL_IRQ_MASK)
        irq_mask_q <= wbyte_q[IRQ_W-1:0];
    end
  end

  // reset cause flags; supply drop flag kept through system reset, watchdog flag set only by a watchdog reset
  always_ff @(posedge clk)
  begin
    if (!por_n)
    begin
      wdg_q  <= 1'b0;
      drop_q <= 1'b0;
    end
    else if (!rst_n)
    begin
      if (cause_supply_drop)
      begin
        drop_q <= 1'b1;
        wdg_q  <= 1'b0;
      end
      else if (cause_watchdog)
        wdg_q <= 1'b1;
      else
        wdg_q <= 1'b0;
    end
    else if (rd_clr)
    begin
      wdg_q  <= 1'b0;
      drop_q <= 1'b0;
    end
    else if (wr_en && wlane_q && wsel == SEL_STATUS && !wbyte_q[BIT_WDG])
      wdg_q <= 1'b0;
  end

  // interrupt events and sticky status
  assign warn_evt   = ana_s.supply_low && !warn_prev_q && irq_en_q;
  assign unlock_evt = lock_prev_q && !ana_s.main_lock;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      warn_prev_q <= 1'b0;
      lock_prev_q <= 1'b0;
      irq_stat_q  <= '0;
      irq         <= 1'b0;
    end
    else
    begin
      warn_prev_q <= ana_s.supply_low;
      lock_prev_q <= ana_s.main_lock;
      irq         <= |(irq_stat_q & irq_mask_q);
      if (warn_evt)
        irq_stat_q[IRQ_WARN] <= 1'b1;
      else if (irq_service_ack)
        irq_stat_q[IRQ_WARN] <= 1'b0;
      else if (wr_en && wlane_q && wsel == SEL_IRQ_STAT
               && wbyte_q[IRQ_WARN])
        irq_stat_q[IRQ_WARN] <= 1'b0;
      if (unlock_evt)
        irq_stat_q[IRQ_UNLOCK] <= 1'b1;
      else if (wr_en && wlane_q && wsel == SEL_IRQ_STAT
               && wbyte_q[IRQ_UNLOCK])
        irq_stat_q[IRQ_UNLOCK] <= 1'b0;
    end
  end

  // helper: cycles since halving request changed
  logic       halve_prev_q;
  logic [6:0] halve_age_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      halve_prev_q <= 1'b0;
      halve_age_q  <= 7'h7f;
    end
    else
    begin
      halve_prev_q <= halve_q;
      if (halve_q != halve_prev_q)
        halve_age_q <= 7'h01;
      else if (halve_age_q != 7'h7f)
        halve_age_q <= halve_age_q + 7'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_FAST_LOCK_RD: assert property (
    rd_clr |=> rdata[7] == $past(ana_s.fast_lock))
    else $error("fast lock bit wrong on read");
  AST_MAIN_LOCK_RD: assert property (
    rd_clr |=> rdata[3] == $past(ana_s.main_lock))
    else $error("main lock bit wrong on read");
  AST_WARN_RD: assert property (
    rd_clr |=> rdata[1] == $past(ana_s.supply_low))
    else $error("warning flag wrong on read");
  AST_READ_CLEARS: assert property (
    rd_clr |=> !wdg_q && !drop_q && rdata[4] == $past(wdg_q))
    else $error("reset flags not cleared by read");
  AST_DROP_KEEPS: assert property (
    @(posedge clk) disable iff (!por_n)
    drop_q && !rd_clr |=> drop_q)
    else $error("supply drop flag lost");
  AST_DROP_CAUSE: assert property (
    @(posedge clk) disable iff (!por_n)
    !rst_n && cause_supply_drop |=> drop_q && !wdg_q)
    else $error("supply drop reset not recorded");
  AST_WARN_IRQ: assert property (
    warn_evt && irq_mask_q[IRQ_WARN] |=> ##1 irq)
    else $error("warning interrupt not raised");
  AST_WARN_GATED: assert property (
    !irq_en_q && !irq_stat_q[IRQ_WARN] |=> !irq_stat_q[IRQ_WARN])
    else $error("warning pending while disabled");
  AST_ACK_CLEARS: assert property (
    irq_service_ack && !warn_evt |=> !irq_stat_q[IRQ_WARN])
    else $error("service entry did not clear pending");
  AST_HALVE_TIME: assert property (
    halve_age_q == 7'(HALVE_CYC) |-> multiplier_halve == halve_q)
    else $error("halving not applied after delay");
  AST_HALVE_HOLD: assert property (
    halve_age_q == 7'h01 |-> $stable(multiplier_halve))
    else $error("halving applied too early");
  AST_WRITE_RESP: assert property (
    wr_en |=> bvalid)
    else $error("write response missing");

  COV_WRITE: cover property (bvalid && bready);
  COV_WARN_IRQ: cover property (warn_evt ##[1:4] irq);
  COV_DROP_READ: cover property (drop_q && rd_clr);
  COV_HALVE: cover property ($rose(multiplier_halve));
endmodule : system_integrity_status_regs

/* system_integrity_status_regs_bench.sv */
// self-checking bench for the system integrity register bank
`timescale 1ns/1ps
module system_integrity_status_regs_bench;
  import sys_integrity_pkg::*;
  logic              clk, rst_n, por_n, cause_watchdog, cause_supply_drop;
  logic              fast_lock_async, main_lock_async, supply_low_async;
  logic              irq_service_ack, irq, multiplier_halve;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [31:0]       wdata, rdata, rd_v, seed;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, osc_trim_low, resp, m_trim;
  logic              m_en, m_fast, m_main, m_low;
  int                err_total, comparisons, cyc;

  system_integrity_status_regs dut_u (
    .clk, .rst_n, .por_n, .cause_watchdog, .cause_supply_drop,
    .fast_lock_async, .main_lock_async, .supply_low_async, .irq_service_ack,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .irq, .osc_trim_low, .multiplier_halve
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic close_out;
    if (err_total == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] nxt(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : nxt

  // expected status word from the model
  function automatic logic [31:0] st(input logic w, input logic dr);
    return {24'h0, m_fast, m_trim, w, m_main, dr, m_low, m_en};
  endfunction : st

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        resp = bresp;
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        rd_v = rdata;
        resp = rresp;
        break;
      end
    end
  endtask : rd

  // reset with cause lines held while rst_n is low
  task automatic do_reset(input logic w, input logic dr, input logic p);
    rst_n <= 1'b0;
    por_n <= p;
    cause_watchdog <= w;
    cause_supply_drop <= dr;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    cause_watchdog <= 1'b0;
    cause_supply_drop <= 1'b0;
    @(posedge clk);
    m_trim = 2'h3;
    m_en = 1'b0;
  endtask : do_reset

  initial
  begin
    {rst_n, por_n, cause_watchdog, cause_supply_drop} = 4'h0;
    {fast_lock_async, main_lock_async, supply_low_async} = 3'h0;
    {irq_service_ack, awvalid, wvalid, arvalid} = 4'h0;
    {m_fast, m_main, m_low} = 3'h0;
    bready = 1'b1;
    rready = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    seed = 32'd14;
    err_total = 0;
    comparisons = 0;
    cyc = 0;
    @(posedge clk);
    do_reset(1'b0, 1'b0, 1'b0);
    chk(osc_trim_low, 32'h3);
    chk({irq, multiplier_halve}, 32'h0);
    rd(8'h00);
    chk(rd_v, st(1'b0, 1'b0));
    rd(8'h04);
    chk(rd_v, 32'h0);
    chk(resp, RESP_OKAY);
    do_reset(1'b1, 1'b0, 1'b1);
    rd(8'h00);
    chk(rd_v, st(1'b1, 1'b0));
    rd(8'h00);
    chk(rd_v, st(1'b0, 1'b0));
    do_reset(1'b1, 1'b0, 1'b1);
    wr(8'h00, 8'h60, 4'h1);
    rd(8'h00);
    chk(rd_v, st(1'b0, 1'b0));
    do_reset(1'b0, 1'b1, 1'b1);
    do_reset(1'b1, 1'b0, 1'b1);
    rd(8'h00);
    chk(rd_v, st(1'b1, 1'b1));
    rd(8'h00);
    chk(rd_v, st(1'b0, 1'b0));
    do_reset(1'b1, 1'b0, 1'b1);
    do_reset(1'b0, 1'b1, 1'b1);
    rd(8'h00);
    chk(rd_v, st(1'b0, 1'b1));
    do_reset(1'b1, 1'b0, 1'b1);
    do_reset(1'b0, 1'b0, 1'b1);
    rd(8'h00);
    chk(rd_v, st(1'b0, 1'b0));
    for (int i = 0; i < 4; i++)
    begin
      seed = nxt(seed);
      wr(8'h00, seed[7:0] & 8'hef, 4'h1);
      m_trim = seed[6:5];
      m_en = seed[0];
      rd(8'h00);
      chk(rd_v, st(1'b0, 1'b0));
      chk(osc_trim_low, m_trim);
    end
    wr(8'h00, 8'h00, 4'he);
    chk(resp, RESP_OKAY);
    rd(8'h00);
    chk(rd_v, st(1'b0, 1'b0));
    wr(8'h10, 8'hff, 4'hf);
    chk(resp, RESP_SLVERR);
    rd(8'h10);
    chk({rd_v[29:0], resp}, {30'h0, RESP_SLVERR});
    fast_lock_async <= 1'b1;
    main_lock_async <= 1'b1;
    m_fast = 1'b1;
    m_main = 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h00);
    chk(rd_v, st(1'b0, 1'b0));
    wr(8'h00, 8'h61, 4'h1);
    m_trim = 2'h3;
    m_en = 1'b1;
    wr(8'h0c, 8'h03, 4'h1);
    supply_low_async <= 1'b1;
    m_low = 1'b1;
    repeat (5) @(posedge clk);
    chk(irq, 32'h1);
    rd(8'h08);
    chk(rd_v, 32'h1);
    rd(8'h00);
    chk(rd_v, st(1'b0, 1'b0));
    irq_service_ack <= 1'b1;
    @(posedge clk);
    irq_service_ack <= 1'b0;
    repeat (3) @(posedge clk);
    chk(irq, 32'h0);
    supply_low_async <= 1'b0;
    m_low = 1'b0;
    wr(8'h00, 8'h60, 4'h1);
    m_en = 1'b0;
    supply_low_async <= 1'b1;
    m_low = 1'b1;
    repeat (5) @(posedge clk);
    chk(irq, 32'h0);
    rd(8'h08);
    chk(rd_v, 32'h0);
    main_lock_async <= 1'b0;
    m_main = 1'b0;
    repeat (5) @(posedge clk);
    chk(irq, 32'h1);
    wr(8'h08, 8'h02, 4'h1);
    repeat (2) @(posedge clk);
    chk(irq, 32'h0);
    wr(8'h04, 8'h80, 4'h1);
    repeat (HALVE_CYC - 10) @(posedge clk);
    chk(multiplier_halve, 32'h0);
    repeat (20) @(posedge clk);
    chk(multiplier_halve, 32'h1);
    rd(8'h04);
    chk(rd_v, 32'h80);
    wr(8'h04, 8'h00, 4'h1);
    repeat (HALVE_CYC + 10) @(posedge clk);
    chk(multiplier_halve, 32'h0);
    close_out();
  end
endmodule : system_integrity_status_regs_bench
